// file: rtl/ldm_consts.svh
// Register offsets, reset values and command fields of the dimming block
// How it works
// - Command byte: rw, chip id, page nibble
// - Pointer increments on each data byte's eighth edge
// - Page 0 duty, 1 scale, 2 function
// - Duty bytes 01h-C6h, write-only, reset zero
// - Average sink current follows duty over 256
// - Scale bytes 01h-C6h, write-only, reset zero
// - Peak current code is global times scale
// - Global current at 01h, reset zero
// - Config at 00h resets to 08h, D3 one
// - Config D0 zero means shutdown
// - Detect field 01 open, 10 short
// - Detection runs once; rearm through 00
// - Scan code selects eleven down to two switches
// - Scan code 1010 stops scanning, sinks only
// - Results 03h-23h read-only, reset zero
// - Resistor select at 02h resets to 33h
// - Thermal 24h, dither 25h, reset zero
// - Reset register 2Fh restores all defaults
// - Only value AEh triggers the soft reset
`ifndef LDM_CONSTS_SVH
`define LDM_CONSTS_SVH
`define LDM_PG_DUTY 4'h0
`define LDM_PG_SCALE 4'h1
`define LDM_PG_FUNC 4'h2
`define LDM_DOT_FIRST 8'h01
`define LDM_DOT_LAST 8'hc6
`define LDM_A_CFG 8'h00
`define LDM_A_GCUR 8'h01
`define LDM_A_RES 8'h02
`define LDM_A_FLT_FIRST 8'h03
`define LDM_A_FLT_LAST 8'h23
`define LDM_A_THERM 8'h24
`define LDM_A_DITH 8'h25
`define LDM_A_SRST 8'h2f
`define LDM_SRST_KEY 8'hae
`define LDM_CFG_RST 8'h08
`define LDM_RES_RST 8'h33
`define LDM_SWS_NOSCAN 4'ha
`define LDM_FD_OPEN 2'b01
`define LDM_FD_SHORT 2'b10
`define LDM_FD_OFF 2'b00
`endif

// file: rtl/ldm_pkg.sv
// Types shared by the dimming block
package ldm_pkg;
  typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA, PH_SKIP} ldm_phase_t;
  typedef struct packed {
    logic [3:0] scan_width_select;
    logic must_one;
    logic [1:0] fault_detect_select;
    logic soft_shutdown_bit;
  } ldm_cfg_t;
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } ldm_spi_t;
endpackage : ldm_pkg

// file: rtl/ldm_top.sv
// Serial register file, scan engine and dimming of the LED matrix
`timescale 1ns/1ps
`include "ldm_consts.svh"
module ldm_top #(
  parameter int NUM_SINK = 18,
  parameter int NUM_SW = 11,
  parameter logic [2:0] CHIP_ID = 3'h2 // Arbitrary identity value
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ldm_pkg::ldm_spi_t spi_pins,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic [197:0] fault_sense,
  output logic [10:0] row_switch_line,
  output logic [17:0] column_sink_line,
  output logic [17:0][15:0] column_sink_level
);
  import ldm_pkg::*;

  localparam int NDOT = 198;
  localparam int NFLT = 33;

  if (NUM_SINK * NUM_SW != NDOT || NUM_SINK != 18) begin : g_chk
    $error("ldm_top: matrix must be 18 by 11");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  ldm_spi_t s1_q, s2_q;
  logic sck_d_q;
  logic [197:0] fs1_q, fs2_q;

  // Two flops per pin; only the second stage feeds logic
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 3'b100;
      s2_q <= 3'b100;
      sck_d_q <= 1'b0;
      fs1_q <= '0;
      fs2_q <= '0;
    end else begin
      s1_q <= spi_pins;
      s2_q <= s1_q;
      sck_d_q <= s2_q.sck;
      fs1_q <= fault_sense;
      fs2_q <= fs1_q;
    end
  end

  logic rise, fall, sel;
  assign sel = !s2_q.cs_n;
  assign rise = sel && s2_q.sck && !sck_d_q;
  assign fall = sel && !s2_q.sck && sck_d_q;

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  ldm_phase_t ph_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q, tx_q, ptr_q, rx;
  logic [3:0] page_q;
  logic rd_q, done, wr;
  assign rx = {sh_q[6:0], s2_q.mosi};
  assign done = rise && bit_q == 3'd7;
  assign wr = done && ph_q == PH_DATA && !rd_q;

  // Registers
  logic [7:0] duty_q [NDOT];
  logic [7:0] scale_q [NDOT];
  logic [5:0] flt_q [NFLT];
  ldm_cfg_t cfg_q;
  logic [7:0] gcur_q, res_q, therm_q, dith_q;

  // Readback; write-only registers read as zero
  function automatic logic [7:0] rdval(input logic [3:0] pg,
                                       input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (pg == `LDM_PG_FUNC && a >= `LDM_A_FLT_FIRST &&
        a <= `LDM_A_FLT_LAST) begin
      v = {2'b00, flt_q[6'(a - `LDM_A_FLT_FIRST)]};
    end
    return v;
  endfunction : rdval

  function automatic logic is_dot(input logic [7:0] a);
    return a >= `LDM_DOT_FIRST && a <= `LDM_DOT_LAST;
  endfunction : is_dot

  // Byte framing, pointer and read shifter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= PH_CMD;
      bit_q <= 3'd0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      page_q <= 4'h0;
      rd_q <= 1'b0;
    end else if (!sel) begin
      ph_q <= PH_CMD;
      bit_q <= 3'd0;
    end else if (rise) begin
      sh_q <= rx;
      bit_q <= bit_q + 3'd1;
      if (done) begin
        case (ph_q)
          PH_CMD: begin
            // Foreign id or unknown page: ignore rest of frame
            if (rx[6:4] == CHIP_ID && rx[3:0] <= `LDM_PG_FUNC) begin
              ph_q <= PH_ADDR;
            end else begin
              ph_q <= PH_SKIP;
            end
            rd_q <= rx[7];
            page_q <= rx[3:0];
          end
          PH_ADDR: begin
            ph_q <= PH_DATA;
            ptr_q <= rx;
            tx_q <= rdval(page_q, rx);
          end
          PH_DATA: begin
            ptr_q <= ptr_q + 8'd1;
            tx_q <= rdval(page_q, ptr_q + 8'd1);
          end
          default: ;
        endcase
      end
    end else if (fall && bit_q != 3'd0) begin
      // Shift only mid-byte so a fresh load shows its top bit first
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  assign spi_miso = tx_q[7];
  assign spi_miso_oe = sel && rd_q && ph_q == PH_DATA;

  // ----------------------------------------------------------------
  // Register writes and soft reset
  // ----------------------------------------------------------------
  logic srst, fwr;
  assign fwr = wr && page_q == `LDM_PG_FUNC;
  assign srst = fwr && ptr_q == `LDM_A_SRST && rx == `LDM_SRST_KEY;

  // Dot pages; soft reset clears them with the rest
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NDOT; i++) begin
        duty_q[i] <= 8'h00;
        scale_q[i] <= 8'h00;
      end
    end else if (srst) begin
      for (int i = 0; i < NDOT; i++) begin
        duty_q[i] <= 8'h00;
        scale_q[i] <= 8'h00;
      end
    end else if (wr && is_dot(ptr_q)) begin
      if (page_q == `LDM_PG_DUTY) begin
        duty_q[8'(ptr_q - 8'd1)] <= rx;
      end else if (page_q == `LDM_PG_SCALE) begin
        scale_q[8'(ptr_q - 8'd1)] <= rx;
      end
    end
  end

  // Function page
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `LDM_CFG_RST;
      gcur_q <= 8'h00;
      res_q <= `LDM_RES_RST;
      therm_q <= 8'h00;
      dith_q <= 8'h00;
    end else if (srst) begin
      cfg_q <= `LDM_CFG_RST;
      gcur_q <= 8'h00;
      res_q <= `LDM_RES_RST;
      therm_q <= 8'h00;
      dith_q <= 8'h00;
    end else if (fwr) begin
      if (ptr_q == `LDM_A_CFG) begin
        cfg_q <= rx;
      end else if (ptr_q == `LDM_A_GCUR) begin
        gcur_q <= rx;
      end else if (ptr_q == `LDM_A_RES) begin
        res_q <= rx;
      end else if (ptr_q == `LDM_A_THERM) begin
        therm_q <= rx;
      end else if (ptr_q == `LDM_A_DITH) begin
        dith_q <= rx;
      end
    end
  end

  // ----------------------------------------------------------------
  // Open and short detection
  // ----------------------------------------------------------------
  logic armed_q, det;
  logic [1:0] fds;
  assign fds = cfg_q.fault_detect_select;
  assign det = armed_q && (fds == `LDM_FD_OPEN || fds == `LDM_FD_SHORT);

  // One capture per trigger; 00 rearms, 11 does nothing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b1;
      for (int i = 0; i < NFLT; i++) flt_q[i] <= 6'h00;
    end else if (srst) begin
      armed_q <= 1'b1;
      for (int i = 0; i < NFLT; i++) flt_q[i] <= 6'h00;
    end else begin
      if (fds == `LDM_FD_OFF) begin
        armed_q <= 1'b1;
      end else if (det) begin
        armed_q <= 1'b0;
        for (int i = 0; i < NFLT; i++) flt_q[i] <= fs2_q[i*6 +: 6];
      end
    end
  end

  // ----------------------------------------------------------------
  // Scan and dimming
  // ----------------------------------------------------------------
  logic [7:0] cnt_q, base;
  logic [3:0] sw_q, nsw;
  logic noscan, on, live;
  assign noscan = cfg_q.scan_width_select >= `LDM_SWS_NOSCAN;
  assign on = cfg_q.soft_shutdown_bit;
  assign live = on && (noscan || sw_q < nsw);
  assign nsw = 4'd11 - cfg_q.scan_width_select;
  assign base = noscan ? 8'd0 : 8'(sw_q * 5'd18);

  // Slot counter spans one switch on-time
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      sw_q <= 4'd0;
    end else if (!on) begin
      cnt_q <= 8'h00;
      sw_q <= 4'd0;
    end else if (!noscan && sw_q >= nsw) begin
      // Width narrowed mid-slot: restart so no idle switch lights
      cnt_q <= 8'h00;
      sw_q <= 4'd0;
    end else begin
      cnt_q <= cnt_q + 8'd1;
      if (cnt_q == 8'hff) begin
        sw_q <= (noscan || sw_q + 4'd1 >= nsw) ? 4'd0 : sw_q + 4'd1;
      end
    end
  end

  // Outputs from flops; shutdown blanks switches and sinks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_switch_line <= '0;
      column_sink_line <= '0;
      column_sink_level <= '0;
    end else begin
      row_switch_line <= (live && !noscan) ? 11'(1 << sw_q) : '0;
      for (int c = 0; c < 18; c++) begin
        column_sink_line[c] <= live && cnt_q < duty_q[base + 8'(c)];
        column_sink_level[c] <= gcur_q * scale_q[base + 8'(c)];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_key; srst; endsequence
  sequence s_dflt; cfg_q == `LDM_CFG_RST && gcur_q == 8'h00; endsequence
  property p_off; !on |=> row_switch_line == '0 && column_sink_line == '0;
  endproperty
  a_off: assert property (p_off) else $error("output in shutdown");
  property p_ptr; done && ph_q == PH_DATA |=> ptr_q == $past(ptr_q) + 8'd1;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer not stepped");
  property p_srst; s_key |=> s_dflt ##1 res_q == `LDM_RES_RST; endproperty
  a_srst: assert property (p_srst) else $error("soft reset lost");
  property p_key; fwr && ptr_q == `LDM_A_SRST && !srst |=> $stable(cfg_q);
  endproperty
  a_key: assert property (p_key) else $error("wrong key reset");
  property p_det; det |=> !det ##1 !det; endproperty
  a_det: assert property (p_det) else $error("detect repeated");
  property p_fd11; fds == 2'b11 |=> $stable(armed_q); endproperty
  a_fd11: assert property (p_fd11) else $error("code 11 detects");
  property p_ro; fwr && ptr_q == `LDM_A_FLT_FIRST && !det |=>
    flt_q[0] == $past(flt_q[0]); endproperty
  a_ro: assert property (p_ro) else $error("result written");
  property p_noscan; on && noscan |=> row_switch_line == '0; endproperty
  a_noscan: assert property (p_noscan) else $error("scan in 1010");
  property p_width; !noscan |=> (row_switch_line >> $past(nsw)) == '0;
  endproperty
  a_width: assert property (p_width) else $error("inactive switch");
  property p_wrap; !noscan && sw_q >= nsw |=> sw_q == 4'd0; endproperty
  a_wrap: assert property (p_wrap) else $error("switch not wrapped");
endmodule : ldm_top

// file: tb/ldm_host_model.sv
// Host serial master model that drives the dimming block
`timescale 1ns/1ps
module ldm_host_model (
  output ldm_pkg::ldm_spi_t spi_pins,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  import ldm_pkg::*;
  logic [7:0] rx_q;
  // Idle: deselected, clock parked low between frames
  initial spi_pins = '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
  // One byte MSB first; set while clock low, read at the rise
  task automatic shift(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      spi_pins.mosi = b[i];
      #62.5 spi_pins.sck = 1'b1;
      rx_q = {rx_q[6:0], spi_miso_oe ? spi_miso : 1'bx};
      #62.5 spi_pins.sck = 1'b0;
    end
    spi_pins.mosi = ~b[0]; // Released line shows no stale bit
  endtask : shift
  // Command, address, then n data bytes; read bytes land in rd_q
  task automatic frame(input logic rw, input logic [2:0] id,
      input logic [3:0] pg, input logic [7:0] a, input int n,
      input logic [15:0] wd, output logic [15:0] rd_q);
    rd_q = '0;
    spi_pins.cs_n = 1'b0;
    #62.5 shift({rw, id, pg});
    shift(a);
    for (int k = 0; k < n; k++) begin
      shift(wd[15-8*k -: 8]);
      rd_q = {rd_q[7:0], rx_q};
    end
    #62.5 spi_pins.cs_n = 1'b1;
    #250;
  endtask : frame
endmodule : ldm_host_model

// file: tb/ldm_top_bench.sv
// Self-checking bench for the dimming block
`timescale 1ns/1ps
module ldm_top_bench;
  import ldm_pkg::*;
  localparam logic [2:0] ID = 3'h2; // Arbitrary identity value
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  ldm_spi_t spi_pins;
  logic spi_miso;
  logic spi_miso_oe;
  logic [197:0] fault_sense = '0;
  logic [10:0] row_switch_line;
  logic [17:0] column_sink_line;
  logic [17:0][15:0] column_sink_level;
  logic [15:0] rd_v;
  logic [10:0] r_or;
  logic [17:0] s_or;
  int n_fail = 0;
  int n_tests = 0;
  // 100 MHz core clock
  always #5 core_clk = ~core_clk;
  ldm_top #(.CHIP_ID(ID)) u_ldm_top (.core_clk(core_clk), .rst_n(rst_n),
    .spi_pins(spi_pins), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .fault_sense(fault_sense), .row_switch_line(row_switch_line),
    .column_sink_line(column_sink_line),
    .column_sink_level(column_sink_level));
  ldm_host_model u_ldm_host_model (.spi_pins(spi_pins),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
  // ----
  // Helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] pg, input logic [7:0] a,
      input logic [7:0] d);
    u_ldm_host_model.frame(1'b0, ID, pg, a, 1, {d, 8'h00}, rd_v);
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n);
    u_ldm_host_model.frame(1'b1, ID, 4'h2, a, n, 16'h0000, rd_v);
  endtask : rd
  // OR of switch and sink outputs over n cycles
  task automatic obs(input int n);
    r_or = '0;
    s_or = '0;
    repeat (n) begin
      @(posedge core_clk) #1;
      r_or |= row_switch_line;
      s_or |= column_sink_line;
    end
  endtask : obs
  // ----
  // Scenarios
  // ----
  task automatic t_idle;
    rd(8'h03, 1);
    chk(32'(rd_v), 32'h0);
    rd(8'h24, 1);
    chk(32'(rd_v), 32'h0);
    obs(300);
    chk({r_or, s_or}, 32'h0);
  endtask : t_idle
  task automatic t_detect;
    @(posedge core_clk) #1 fault_sense = {33{6'h2d}};
    wr(4'h2, 8'h01, 8'h0f);
    wr(4'h2, 8'h00, 8'h0a);
    @(posedge core_clk) #1 fault_sense = '0;
    rd(8'h22, 2);
    chk(32'(rd_v), 32'h2d2d);
    wr(4'h2, 8'h00, 8'h0a);
    rd(8'h03, 1);
    chk(32'(rd_v), 32'h2d);
    wr(4'h2, 8'h00, 8'h08);
    wr(4'h2, 8'h00, 8'h0c);
    wr(4'h2, 8'h03, 8'h3f);
    rd(8'h03, 1);
    chk(32'(rd_v), 32'h0);
    wr(4'h2, 8'h00, 8'h08);
    @(posedge core_clk) #1 fault_sense = {33{6'h2d}};
    wr(4'h2, 8'h00, 8'h0e);
    rd(8'h03, 1);
    chk(32'(rd_v), 32'h0);
    @(posedge core_clk) #1 fault_sense = '0;
  endtask : t_detect
  task automatic t_pwm;
    int on0;
    int on1;
    int k;
    on0 = 0;
    on1 = 0;
    k = 0;
    u_ldm_host_model.frame(1'b0, ID, 4'h0, 8'h01, 2, 16'h8040, rd_v);
    wr(4'h1, 8'h01, 8'h10);
    wr(4'h2, 8'h00, 8'h09);
    // Skip the slot cut short by the enabling write
    while (row_switch_line !== 11'h002 && k < 8000) begin
      @(posedge core_clk) #1 k++;
    end
    while (row_switch_line !== 11'h001 && k < 8000) begin
      @(posedge core_clk) #1 k++;
    end
    chk(32'(column_sink_level[0]), 32'h00f0);
    while (row_switch_line === 11'h001 && k < 8000) begin
      on0 += int'(column_sink_line[0]);
      on1 += int'(column_sink_line[1]);
      @(posedge core_clk) #1 k++;
    end
    chk(32'(k >= 8000), 32'h0);
    chk(32'(on0), 32'h80);
    chk(32'(on1), 32'h40);
  endtask : t_pwm
  task automatic t_width;
    wr(4'h2, 8'h00, 8'h99);
    obs(800);
    chk(32'(r_or), 32'h003);
    wr(4'h2, 8'h00, 8'ha9);
    obs(600);
    chk({r_or, s_or[1:0]}, 32'h3);
    wr(4'h2, 8'h00, 8'h08);
    obs(300);
    chk({r_or, s_or}, 32'h0);
  endtask : t_width
  task automatic t_reset;
    wr(4'h2, 8'h00, 8'h99);
    wr(4'h2, 8'h2f, 8'h00);
    obs(600);
    chk(32'(s_or[0]), 32'h1);
    wr(4'h2, 8'h2f, 8'hae);
    obs(600);
    chk({r_or, s_or}, 32'h0);
    u_ldm_host_model.frame(1'b0, ID ^ 3'h1, 4'h2, 8'h00, 1, 16'h0900, rd_v);
    obs(600);
    chk(32'(r_or), 32'h0);
    u_ldm_host_model.frame(1'b0, ID, 4'h3, 8'h00, 1, 16'h0900, rd_v);
    obs(600);
    chk(32'(r_or), 32'h0);
    wr(4'h2, 8'h00, 8'h09);
    obs(600);
    chk({r_or != 11'h0, s_or}, 32'h40000);
  endtask : t_reset
  // Verdict and end of run
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  // Watchdog sized well above the expected run
  initial begin
    #1ms n_fail++;
    complete_run;
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    t_idle;
    t_detect;
    t_pwm;
    t_width;
    t_reset;
    complete_run;
  end
endmodule : ldm_top_bench
